// ### ppfs_board_model.sv
// board and peripheral model facing the pin function select block
module ppfs_board_model (
  input wire logic clk,
  input wire logic por_req,
  input wire logic strap,
  input wire logic ftest,
  output logic power_on_reset_input_n,
  output logic debug_reset_in,
  output logic factory_test_enable_n,
  output logic [8:0] src
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [4:0] cnt_reg; // cycles since power-on release

  initial begin
    src = 9'h001;
    debug_reset_in = 1'b0;
    cnt_reg = 5'h00;
  end

  // factory test stays off unless the bench asks for it
  assign factory_test_enable_n = !ftest;
  assign power_on_reset_input_n = !por_req;

  // peripheral sources: shift pattern, so every source differs in time
  always @(posedge clk) begin
    src <= {src[7:0], src[8] ^ src[4]};
  end

  // debug strap: level held through power-on, then driven low once and held low
  always @(posedge clk) begin
    if (por_req) begin
      cnt_reg <= 5'h00;
      debug_reset_in <= strap;
    end else begin
      if (cnt_reg != 5'h1F) begin
        cnt_reg <= cnt_reg + 5'h01;
      end
      // low late enough for the bench to see the debug system armed first
      if (cnt_reg == 5'h0C) begin
        debug_reset_in <= 1'b0;
      end
    end
  end
endmodule

// ### ppfs_pin_mux.sv
// pin function multiplexer with avalon register access and debug strap capture
`include "ppfs_regs.svh"

module ppfs_pin_mux (
  input wire logic clk,
  input wire logic srst,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // pin levels from the pads
  input wire logic port6_bit3_in,
  input wire logic port6_bit1_in,
  input wire logic port6_bit0_in,
  input wire logic port2_bit0_in,
  input wire logic port5_bit0_in,
  input wire logic port5_bit2_in,
  input wire logic port5_bit3_in,
  input wire logic port5_bit4_in,
  input wire logic port5_bit8_in,
  input wire logic port5_bit9_in,
  input wire logic factory_test_enable_n,
  input wire logic debug_reset_in,
  input wire logic power_on_reset_input_n,
  // pad drivers
  output logic port6_bit3_out,
  output logic port6_bit3_oe,
  output logic port6_bit1_out,
  output logic port6_bit1_oe,
  output logic port6_bit0_out,
  output logic port6_bit0_oe,
  output logic port2_bit0_out,
  output logic port2_bit0_oe,
  // alternate output sources from peripherals
  input wire logic capture3_ch2_out,
  input wire logic capture3_ch1_out,
  input wire logic capture3_ch0_out,
  input wire logic timer3_toggle_latch,
  input wire logic serial1_ch1_select0,
  input wire logic serial1_ch1_data_out,
  input wire logic analog_mux_ctrl1,
  input wire logic analog_mux_ctrl0,
  input wire logic debug_break_out,
  input wire logic [3:0] hardware_owned_en,
  input wire logic [3:0] hardware_owned_output,
  // routed inputs to peripherals
  output logic [9:0] gp_input_level,
  output logic analog_channel_0,
  output logic analog_channel_2,
  output logic analog_channel_3,
  output logic analog_channel_4,
  output logic analog_channel_8,
  output logic analog_channel_9,
  output logic analog_channel_16,
  output logic analog_channel_17,
  output logic analog_channel_19,
  output logic serial1_ch1_ctrl_in_d,
  output logic converter_trigger_f,
  output logic converter_trigger_e,
  output logic capture3_trap_in_b,
  output logic serial1_ch1_data_in_a,
  output logic event_req1_trigger6,
  output logic converter_gate_g,
  output logic serial1_ch1_data_in_e,
  output logic scan_data_in_a,
  output logic timer3_count_gate_a,
  output logic capture3_t12_run_b,
  output logic timer3_updown_a,
  output logic scan_mode_sel_a,
  output logic capture_t12_run_c,
  output logic capture_t13_run_c,
  output logic capcom_timer7_count,
  output logic can0_receive_c,
  output logic capture3_ch0_in_b,
  output logic timer5_count_gate_b,
  // debug and test status
  output logic factory_test_mode,
  output logic debug_active,
  output logic debug_system_reset
);
  import ppfs_pkg::*;

  // ----------------------------------------------------------------
  // state and reset value
  // ----------------------------------------------------------------
  localparam ppfs_state_t ST_RST = '{
    sync1: `PPFS_SYNC_RST,
    sync2: `PPFS_SYNC_RST,
    sync3: `PPFS_SYNC_RST,
    filt: `PPFS_SYNC_RST,
    sel: {4{`PPFS_SEL_RST}},
    gp_out: `PPFS_GPOUT_RST,
    waitreq: 1'h1,
    default: '0
  };

  ppfs_state_t st_reg; // registered state
  ppfs_state_t st_next; // its next value
  logic [12:0] pin_vec; // raw pad levels
  logic [3:0] src [4]; // output sources per pin, general first
  logic [3:0] avail [4]; // which codes name a real source

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // a change counts once the second and third stages agree
  function automatic logic [12:0] agree_filter(input logic [12:0] s2,
                                               input logic [12:0] s3,
                                               input logic [12:0] cur);
    agree_filter = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & cur);
  endfunction

  // byte offset of the selection word of one output pin
  function automatic logic [7:0] sel_offset(input int k);
    sel_offset = `PPFS_SEL_BASE + 8'(`PPFS_SEL_STEP * k);
  endfunction

  // returns {enable, level} for one pin
  function automatic logic [1:0] pick_source(input ppfs_sel_t sel,
                                             input logic [3:0] s,
                                             input logic [3:0] av,
                                             input logic hw_en,
                                             input logic hw_val);
    logic [1:0] code;
    code = sel[1:0];
    if (hw_en) begin
      pick_source = {1'h1, hw_val};
    end else if (sel[`PPFS_SEL_EN_BIT] && av[code]) begin
      pick_source = {1'h1, s[code]};
    end else begin
      pick_source = 2'h0;
    end
  endfunction

  // read data for an address; unmapped offsets read zero
  function automatic logic [31:0] read_word(input logic [7:0] a,
                                            input ppfs_state_t s);
    logic [31:0] w;
    w = 32'h0;
    for (int k = 0; k < 4; k++) begin
      if (a == sel_offset(k)) begin
        w[3:0] = s.sel[k];
      end
    end
    if (a == `PPFS_GPOUT_OFS) begin
      w[3:0] = s.gp_out;
    end
    if (a == `PPFS_STATUS_OFS) begin
      w[12:0] = s.filt;
      w[`PPFS_ST_DBGACT_BIT] = s.debug_active;
      w[`PPFS_ST_OE_LSB +: 4] = s.pin_oe;
    end
    read_word = w;
  endfunction

  // ----------------------------------------------------------------
  // source tables
  // ----------------------------------------------------------------
  // pad vector; port5 pins only ever feed inputs
  assign pin_vec = {power_on_reset_input_n, debug_reset_in, factory_test_enable_n,
                    port5_bit9_in, port5_bit8_in, port5_bit4_in, port5_bit3_in,
                    port5_bit2_in, port5_bit0_in, port2_bit0_in, port6_bit0_in,
                    port6_bit1_in, port6_bit3_in};

  // output choices, index = low two bits of the code
  always_comb begin
    src[0] = {serial1_ch1_select0, timer3_toggle_latch, capture3_ch2_out,
              st_reg.gp_out[0]};
    src[1] = {serial1_ch1_data_out, timer3_toggle_latch, analog_mux_ctrl1,
              st_reg.gp_out[1]};
    src[2] = {debug_break_out, capture3_ch1_out, analog_mux_ctrl0,
              st_reg.gp_out[2]};
    src[3] = {1'h0, capture3_ch0_out, 1'h0, st_reg.gp_out[3]};
    avail[0] = `PPFS_AVAIL_FULL;
    avail[1] = `PPFS_AVAIL_FULL;
    avail[2] = `PPFS_AVAIL_FULL;
    avail[3] = `PPFS_AVAIL_P20; // no first or third choice here
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    // three-stage synchroniser, first stage read only by the second
    st_next.sync1 = pin_vec;
    st_next.sync2 = st_reg.sync1;
    st_next.sync3 = st_reg.sync2;
    st_next.filt = agree_filter(st_reg.sync2, st_reg.sync3, st_reg.filt);
    // strap caught on the rising edge of the power-on input
    if (!st_reg.filt[`PPFS_IN_POR] && st_next.filt[`PPFS_IN_POR]) begin
      st_next.debug_active = st_next.filt[`PPFS_IN_DBG];
    end
    // a low debug reset input resets an active debug system
    st_next.debug_sys_rst = st_reg.debug_active && !st_reg.filt[`PPFS_IN_DBG];
    // low test input means factory test modes
    st_next.ftest_mode = !st_reg.filt[`PPFS_IN_FTEST];
    // pad drivers, registered so the pads never see a glitch
    for (int k = 0; k < 4; k++) begin
      {st_next.pin_oe[k], st_next.pin_out[k]} =
        pick_source(st_reg.sel[k], src[k], avail[k],
                    hardware_owned_en[k], hardware_owned_output[k]);
    end
    // bus: one wait cycle, then a single answer cycle
    st_next.waitreq = 1'h1;
    if (st_reg.waitreq && (avs_read || avs_write)) begin
      st_next.waitreq = 1'h0;
      st_next.rdata = read_word(avs_address, st_reg);
    end
    // writes land at the edge that ends the answer cycle
    if (!st_reg.waitreq && avs_write && avs_byteenable[0]) begin
      for (int k = 0; k < 4; k++) begin
        if (avs_address == sel_offset(k)) begin
          st_next.sel[k] = avs_writedata[3:0];
        end
      end
      if (avs_address == `PPFS_GPOUT_OFS) begin
        st_next.gp_out = avs_writedata[3:0];
      end
    end
  end

  // state register, synchronous reset
  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from the state register
  // ----------------------------------------------------------------
  assign avs_readdata = st_reg.rdata;
  assign avs_waitrequest = st_reg.waitreq;
  assign port6_bit3_out = st_reg.pin_out[0];
  assign port6_bit3_oe = st_reg.pin_oe[0];
  assign port6_bit1_out = st_reg.pin_out[1];
  assign port6_bit1_oe = st_reg.pin_oe[1];
  assign port6_bit0_out = st_reg.pin_out[2];
  assign port6_bit0_oe = st_reg.pin_oe[2];
  assign port2_bit0_out = st_reg.pin_out[3];
  assign port2_bit0_oe = st_reg.pin_oe[3];
  assign gp_input_level = st_reg.filt[9:0];
  // port6 and port2 inputs run in parallel with any output choice
  assign serial1_ch1_ctrl_in_d = st_reg.filt[0];
  assign converter_trigger_f = st_reg.filt[0];
  assign analog_channel_17 = st_reg.filt[1];
  assign converter_trigger_e = st_reg.filt[1];
  assign capture3_trap_in_b = st_reg.filt[1];
  assign serial1_ch1_data_in_a = st_reg.filt[1];
  assign event_req1_trigger6 = st_reg.filt[1];
  assign analog_channel_16 = st_reg.filt[2];
  assign converter_gate_g = st_reg.filt[2];
  assign serial1_ch1_data_in_e = st_reg.filt[2];
  assign can0_receive_c = st_reg.filt[3];
  assign capture3_ch0_in_b = st_reg.filt[3];
  assign analog_channel_19 = st_reg.filt[3];
  assign timer5_count_gate_b = st_reg.filt[3];
  // input-only port5 pins
  assign analog_channel_0 = st_reg.filt[`PPFS_IN_P50];
  assign analog_channel_2 = st_reg.filt[`PPFS_IN_P52];
  assign scan_data_in_a = st_reg.filt[`PPFS_IN_P52];
  assign analog_channel_3 = st_reg.filt[`PPFS_IN_P53];
  assign timer3_count_gate_a = st_reg.filt[`PPFS_IN_P53];
  assign analog_channel_4 = st_reg.filt[`PPFS_IN_P54];
  assign capture3_t12_run_b = st_reg.filt[`PPFS_IN_P54];
  assign timer3_updown_a = st_reg.filt[`PPFS_IN_P54];
  assign scan_mode_sel_a = st_reg.filt[`PPFS_IN_P54];
  assign analog_channel_8 = st_reg.filt[`PPFS_IN_P58];
  assign capture_t12_run_c = st_reg.filt[`PPFS_IN_P58];
  assign capture_t13_run_c = st_reg.filt[`PPFS_IN_P58];
  assign analog_channel_9 = st_reg.filt[`PPFS_IN_P59];
  assign capcom_timer7_count = st_reg.filt[`PPFS_IN_P59];
  // test and debug status
  assign factory_test_mode = st_reg.ftest_mode;
  assign debug_active = st_reg.debug_active;
  assign debug_system_reset = st_reg.debug_sys_rst;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // request accepted, one answer cycle, then wait again
  sequence answer_pulse;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  // pin held steady long enough to pass the filter
  sequence p53_steady;
    $stable(port5_bit3_in) [*4];
  endsequence

  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> answer_pulse) else $error("bus answer not one cycle after request");

  sel_write_a: assert property (avs_write && !avs_waitrequest && avs_byteenable[0]
    && avs_address == `PPFS_SEL_BASE |=> st_reg.sel[0] == $past(avs_writedata[3:0]))
    else $error("selection write lost");

  general_route_a: assert property (st_reg.sel[1] == 4'h8 && !hardware_owned_en[1]
    |=> port6_bit1_oe && port6_bit1_out == $past(st_reg.gp_out[1]))
    else $error("general output not routed");

  sel_disable_a: assert property (!st_reg.sel[0][3] && !hardware_owned_en[0]
    |=> !port6_bit3_oe) else $error("driver on with disabled code");

  p20_alt1_off_a: assert property (st_reg.sel[3] == 4'h9 && !hardware_owned_en[3]
    |=> !port2_bit0_oe) else $error("missing source drove pin");

  p20_alt2_a: assert property (st_reg.sel[3] == 4'hA && !hardware_owned_en[3]
    |=> port2_bit0_oe && port2_bit0_out == $past(capture3_ch0_out))
    else $error("second choice wrong on port2 bit0");

  p63_alt1_a: assert property (st_reg.sel[0] == 4'h9 && !hardware_owned_en[0]
    |=> port6_bit3_oe && port6_bit3_out == $past(capture3_ch2_out))
    else $error("first choice wrong on port6 bit3");

  p61_alt3_a: assert property (st_reg.sel[1] == 4'hB && !hardware_owned_en[1]
    |=> port6_bit1_oe && port6_bit1_out == $past(serial1_ch1_data_out))
    else $error("third choice wrong on port6 bit1");

  p60_alt3_a: assert property (st_reg.sel[2] == 4'hF && !hardware_owned_en[2]
    |=> port6_bit0_oe && port6_bit0_out == $past(debug_break_out))
    else $error("third choice wrong on port6 bit0");

  hw_owned_a: assert property (hardware_owned_en[2]
    |=> port6_bit0_oe && port6_bit0_out == $past(hardware_owned_output[2]))
    else $error("hardware output overridden");

  debug_sample_a: assert property ($rose(st_reg.filt[`PPFS_IN_POR])
    |-> debug_active == st_reg.filt[`PPFS_IN_DBG])
    else $error("debug strap not caught");

  debug_hold_a: assert property (!$rose(st_reg.filt[`PPFS_IN_POR])
    |-> $stable(debug_active)) else $error("debug flag moved");

  input_route_a: assert property (p53_steady
    |=> timer3_count_gate_a == $past(port5_bit3_in))
    else $error("port5 bit3 not routed");

endmodule

// ### ppfs_pkg.sv
// types shared by the pin function select block
package ppfs_pkg;
  // one 4-bit output source selection field
  typedef logic [3:0] ppfs_sel_t;
  // whole state of the block, registered in one place
  typedef struct packed {
    logic [12:0] sync1;
    logic [12:0] sync2;
    logic [12:0] sync3;
    logic [12:0] filt;
    ppfs_sel_t [3:0] sel;
    logic [3:0] gp_out;
    logic [3:0] pin_out;
    logic [3:0] pin_oe;
    logic debug_active;
    logic debug_sys_rst;
    logic ftest_mode;
    logic waitreq;
    logic [31:0] rdata;
  } ppfs_state_t;
endpackage

// ### ppfs_regs.svh
// register offsets, field positions and reset values of the pin function select block
`ifndef PPFS_REGS_SVH
`define PPFS_REGS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------
`define PPFS_SEL_BASE 8'h00
`define PPFS_SEL_STEP 8'h04
`define PPFS_GPOUT_OFS 8'h10
`define PPFS_STATUS_OFS 8'h14

// ----------------------------------------------------------------
// fields and codes
// ----------------------------------------------------------------
`define PPFS_SEL_EN_BIT 3
`define PPFS_AVAIL_FULL 4'hF
`define PPFS_AVAIL_P20 4'h5
`define PPFS_ST_DBGACT_BIT 13
`define PPFS_ST_OE_LSB 16

// ----------------------------------------------------------------
// index of each pin in the synchroniser vector
// ----------------------------------------------------------------
`define PPFS_IN_P50 4
`define PPFS_IN_P52 5
`define PPFS_IN_P53 6
`define PPFS_IN_P54 7
`define PPFS_IN_P58 8
`define PPFS_IN_P59 9
`define PPFS_IN_FTEST 10
`define PPFS_IN_DBG 11
`define PPFS_IN_POR 12

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PPFS_SEL_RST 4'h0
`define PPFS_GPOUT_RST 4'h0
// factory and power-on inputs idle high, so their stages start high: a plain
// srst must not look like a power-on release and capture the debug strap
`define PPFS_SYNC_RST 13'h1400

`endif

// ### tb_port_pin_function_select.sv
// self-checking testbench of the pin function select block
module tb_port_pin_function_select;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam logic [3:0] GP_VAL = 4'hA; // general output pattern
  logic clk, srst, avs_read, avs_write, avs_waitrequest;
  logic [7:0] avs_address;
  logic [3:0] avs_byteenable, pout, poe, lvl, hw_en, hw_val;
  logic [31:0] avs_writedata, avs_readdata, rdat;
  logic [9:0] pad, gp_input_level; // board levels, filtered levels
  logic [8:0] src, src_q; // sources and their copy one edge late
  logic [27:0] rt; // routed peripheral inputs
  logic factory_test_mode, debug_active, debug_system_reset, en;
  logic power_on_reset_input_n, debug_reset_in, factory_test_enable_n;
  logic por_req, strap, ftest;
  int n_fail, checks_done, cyc, i, p, c;

  // wire level: the block wins while it drives the pad
  assign lvl = (poe & pout) | (~poe & pad[3:0]);

  ppfs_board_model i_ppfs_board_model (.clk, .por_req, .strap, .ftest,
    .power_on_reset_input_n, .debug_reset_in, .factory_test_enable_n, .src);

  ppfs_pin_mux i_ppfs_pin_mux (.clk, .srst, .avs_address, .avs_read, .avs_write,
    .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .port6_bit3_in(lvl[0]), .port6_bit1_in(lvl[1]), .port6_bit0_in(lvl[2]),
    .port2_bit0_in(lvl[3]), .port5_bit0_in(pad[4]), .port5_bit2_in(pad[5]),
    .port5_bit3_in(pad[6]), .port5_bit4_in(pad[7]), .port5_bit8_in(pad[8]),
    .port5_bit9_in(pad[9]), .factory_test_enable_n, .debug_reset_in, .power_on_reset_input_n,
    .port6_bit3_out(pout[0]), .port6_bit3_oe(poe[0]), .port6_bit1_out(pout[1]),
    .port6_bit1_oe(poe[1]), .port6_bit0_out(pout[2]), .port6_bit0_oe(poe[2]),
    .port2_bit0_out(pout[3]), .port2_bit0_oe(poe[3]),
    .capture3_ch2_out(src[0]), .timer3_toggle_latch(src[1]), .serial1_ch1_select0(src[2]),
    .analog_mux_ctrl1(src[3]), .serial1_ch1_data_out(src[4]), .analog_mux_ctrl0(src[5]),
    .capture3_ch1_out(src[6]), .debug_break_out(src[7]), .capture3_ch0_out(src[8]),
    .hardware_owned_en(hw_en), .hardware_owned_output(hw_val), .gp_input_level,
    .analog_channel_0(rt[13]), .analog_channel_2(rt[12]), .analog_channel_3(rt[10]),
    .analog_channel_4(rt[8]), .analog_channel_8(rt[4]), .analog_channel_9(rt[1]),
    .analog_channel_16(rt[20]), .analog_channel_17(rt[25]), .analog_channel_19(rt[15]),
    .serial1_ch1_ctrl_in_d(rt[27]), .converter_trigger_f(rt[26]),
    .converter_trigger_e(rt[24]), .capture3_trap_in_b(rt[23]),
    .serial1_ch1_data_in_a(rt[22]), .event_req1_trigger6(rt[21]),
    .converter_gate_g(rt[19]), .serial1_ch1_data_in_e(rt[18]), .scan_data_in_a(rt[11]),
    .timer3_count_gate_a(rt[9]), .capture3_t12_run_b(rt[7]), .timer3_updown_a(rt[6]),
    .scan_mode_sel_a(rt[5]), .capture_t12_run_c(rt[3]), .capture_t13_run_c(rt[2]),
    .capcom_timer7_count(rt[0]), .can0_receive_c(rt[17]), .capture3_ch0_in_b(rt[16]),
    .timer5_count_gate_b(rt[14]), .factory_test_mode, .debug_active, .debug_system_reset);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task conclude;
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // one avalon transfer; holds the request until waitrequest is seen low
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (n >= 40) n_fail++; // a slave that never answers counts as a mismatch
    rdat = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // expected pad level for a pin and code, from the previous edge's sources
  function automatic logic pick(input int q, input logic [1:0] k, input logic [8:0] s);
    logic [3:0] v;
    case (q)
      0: v = {s[2], s[1], s[0], GP_VAL[0]};
      1: v = {s[4], s[1], s[3], GP_VAL[1]};
      2: v = {s[7], s[6], s[5], GP_VAL[2]};
      default: v = {1'b0, s[8], 1'b0, GP_VAL[3]};
    endcase
    return v[k];
  endfunction

  function automatic logic [27:0] route_exp(input logic [9:0] q);
    return {{2{q[0]}}, {5{q[1]}}, {3{q[2]}}, {4{q[3]}}, q[4], {2{q[5]}}, {2{q[6]}},
            {4{q[7]}}, {3{q[8]}}, {2{q[9]}}};
  endfunction

  // ----------------------------------------------------------------
  // clock, copy of sources, timeout
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    src_q <= src;
    cyc++;
    // whole run needs about 1000 cycles
    if (cyc == 6000) begin
      n_fail++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {srst, por_req} = 2'b10;
    {avs_read, avs_write, strap, ftest} = 4'h0;
    {avs_address, avs_writedata, pad, hw_en, hw_val} = '0;
    avs_byteenable = 4'hF;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    // reset values, unmapped read, write with the low lane disabled
    for (i = 0; i < 5; i++) begin
      xfer(1'b0, 8'(i * 4), 32'h0);
      chk(rdat, 32'h0);
    end
    xfer(1'b0, 8'h20, 32'h0);
    chk(rdat, 32'h0);
    xfer(1'b0, 8'h14, 32'h0);
    chk(rdat, 32'h1400);
    avs_byteenable <= 4'h0;
    xfer(1'b1, 8'h10, 32'(GP_VAL));
    avs_byteenable <= 4'hF;
    xfer(1'b0, 8'h10, 32'h0);
    chk(rdat, 32'h0);
    xfer(1'b1, 8'h10, 32'(GP_VAL));
    xfer(1'b0, 8'h10, 32'h0);
    chk(rdat, 32'(GP_VAL));
    // input routing, one pad high then one pad low
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      pad <= (i < 10) ? 10'(1 << i) : ~10'(1 << (i - 10));
      repeat (6) @(posedge clk);
      @(negedge clk);
      chk(32'(gp_input_level), 32'(pad));
      chk(32'(rt), 32'(route_exp(pad)));
    end
    // every selection code on every output pin
    for (p = 0; p < 4; p++) begin
      for (c = 0; c < 16; c++) begin
        xfer(1'b1, 8'(p * 4), 32'(c));
        repeat (3) @(posedge clk);
        repeat (6) begin
          @(negedge clk);
          en = c[3] && (p != 3 || !c[0]);
          chk(32'(poe[p]), 32'(en));
          if (en) chk(32'(pout[p]), 32'(pick(p, c[1:0], src_q)));
        end
      end
    end
    // hardware-owned output beats the code 0xF left on every pin by the sweep
    for (i = 0; i < 2; i++) begin
      @(posedge clk);
      hw_en <= 4'hF;
      hw_val <= i ? 4'hA : 4'h5;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk(32'(poe), 32'hF);
      chk(32'(pout), i ? 32'hA : 32'h5);
    end
    @(posedge clk);
    hw_en <= 4'h0;
    // factory test input
    ftest <= 1'b1;
    repeat (8) @(posedge clk);
    chk(32'(factory_test_mode), 32'h1);
    ftest <= 1'b0;
    repeat (8) @(posedge clk);
    chk(32'(factory_test_mode), 32'h0);
    // debug strap high at power-on release, then driven low and held by the board
    por_req <= 1'b1;
    strap <= 1'b1;
    repeat (10) @(posedge clk);
    por_req <= 1'b0;
    repeat (9) @(posedge clk);
    chk(32'(debug_active), 32'h1);
    chk(32'(debug_system_reset), 32'h0);
    repeat (16) @(posedge clk);
    chk(32'(debug_system_reset), 32'h1);
    xfer(1'b0, 8'h14, 32'h0);
    chk(32'(rdat[13]), 32'h1);
    chk(32'(rdat[19:16]), 32'h7);
    // strap low: debug turns off
    por_req <= 1'b1;
    strap <= 1'b0;
    repeat (10) @(posedge clk);
    por_req <= 1'b0;
    repeat (10) @(posedge clk);
    chk(32'(debug_active), 32'h0);
    conclude();
  end
endmodule
